// File: pkg/telemetry_regs_pkg.sv
package telemetry_regs_pkg;

    // ----------------------------------------------------------------
    // Command codes
    // ----------------------------------------------------------------
    localparam logic [7:0] cmd_energy_accumulator_reading = 8'h86;
    localparam logic [7:0] cmd_input_voltage_reading      = 8'h88;
    localparam logic [7:0] cmd_input_current_reading      = 8'h89;
    localparam logic [7:0] cmd_output_voltage_reading     = 8'h8b;
    localparam logic [7:0] cmd_output_current_reading     = 8'h8c;
    localparam logic [7:0] cmd_temperature_reading        = 8'h8d;
    localparam logic [7:0] cmd_input_power_reading        = 8'h97;
    localparam logic [7:0] cmd_device_setup               = 8'hd0;
    localparam logic [7:0] cmd_peak_input_voltage         = 8'hd1;
    localparam logic [7:0] cmd_peak_output_current        = 8'hd2;
    localparam logic [7:0] cmd_peak_input_power           = 8'hd3;
    localparam logic [7:0] cmd_peak_temperature           = 8'hd4;
    localparam logic [7:0] cmd_peak_clear_command         = 8'hd5;
    localparam logic [7:0] cmd_report_averaging_select    = 8'hdd;
    localparam logic [7:0] cmd_peak_output_voltage        = 8'hfd;

    // ----------------------------------------------------------------
    // Reset values and field layout
    // ----------------------------------------------------------------
    localparam logic [15:0] setup_reset      = 16'h0000;
    localparam logic [3:0]  avg_reset        = 4'h0;
    localparam logic [15:0] peak_reset       = 16'h0000;
    localparam logic [15:0] setup_used_mask  = 16'hfbe3;
    localparam int          severe_filt_lsb  = 14;
    localparam int          iadc_dis_bit     = 13;
    localparam int          ss_cfg_lsb       = 11;
    localparam int          pg_th_lsb        = 8;
    localparam int          ocp_ratio_bit    = 7;
    localparam int          mocp_lsb         = 5;
    localparam int          warn_avg_lsb     = 0;
    localparam int          num_peaks        = 5;
    localparam int          ten_bit_w        = 10;

    // ----------------------------------------------------------------
    // Decoded setting encodings
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        filt_10us  = 2'b00,
        filt_100us = 2'b01,
        filt_none  = 2'b10,
        filt_2us   = 2'b11
    } severe_filter_t;

    typedef enum logic [1:0] {
        mocp_100us  = 2'b00,
        mocp_250ms  = 2'b01,
        mocp_100ms  = 2'b10,
        mocp_12p5us = 2'b11
    } mocp_timeout_t;

    // Soft-start delays in microseconds and their cycle counts at 10 MHz.
    localparam int clk_period_ns  = 100;
    localparam int ss_2p5ms_us    = 2500;
    localparam int ss_12p5ms_us   = 12500;
    localparam int ss_22p5ms_us   = 22500;
    localparam int ss_2p5ms_cyc   = ss_2p5ms_us * 1000 / clk_period_ns;
    localparam int ss_12p5ms_cyc  = ss_12p5ms_us * 1000 / clk_period_ns;
    localparam int ss_22p5ms_cyc  = ss_22p5ms_us * 1000 / clk_period_ns;

    // Direct-format coefficients.
    localparam logic signed [15:0] volt_m = 16'sd7578;
    localparam logic signed [15:0] volt_b = 16'sd0;
    localparam logic signed [7:0]  volt_r = -8'sd2;
    localparam logic signed [15:0] temp_m = 16'sd199;
    localparam logic signed [15:0] temp_b = 16'sd7046;
    localparam logic signed [7:0]  temp_r = -8'sd2;
    localparam logic signed [15:0] curr_b = -16'sd4300;
    localparam logic signed [7:0]  curr_r = -8'sd3;
    localparam logic signed [15:0] pwr_b  = -16'sd9100;
    localparam logic signed [7:0]  pwr_r  = -8'sd2;

endpackage

// File: logic/peak_hold.sv
`timescale 1ns/10ps
module peak_hold
    import telemetry_regs_pkg::*;
#(
    parameter int w = 16
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         sample_valid,
    input  wire logic [w-1:0] sample,
    input  wire logic         clear,
    output logic      [w-1:0] peak
);

    logic [w-1:0] peak_r;

    // A clear and a sample of any size in the same cycle keep the sample, so no event is lost.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            peak_r <= peak_reset[w-1:0]; // R12
        end else if (sample_valid && (clear || sample > peak_r)) begin
            peak_r <= sample; // R16
        end else if (clear) begin
            peak_r <= peak_reset[w-1:0]; // R12
        end
    end

    assign peak = peak_r;

endmodule

// File: logic/setup_decode.sv
`timescale 1ns/10ps
module setup_decode
    import telemetry_regs_pkg::*;
(
    input  wire logic [15:0] setup,
    input  wire logic [3:0]  avg_sel,
    output severe_filter_t   severe_filter,
    output logic             iadc_enable,
    output logic [23:0]      soft_start_cycles,
    output logic [1:0]       power_good_threshold_sel,
    output logic             severe_ratio_high,
    output mocp_timeout_t    mocp_timeout,
    output logic [3:0]       warn_avg_samples,
    output logic [15:0]      report_avg_samples
);

    always_comb begin
        severe_filter            = severe_filter_t'(setup[severe_filt_lsb +: 2]); // R2
        iadc_enable              = !setup[iadc_dis_bit]; // R3
        power_good_threshold_sel = setup[pg_th_lsb +: 2]; // R5
        severe_ratio_high        = setup[ocp_ratio_bit]; // R6
        mocp_timeout             = mocp_timeout_t'(setup[mocp_lsb +: 2]); // R7
        warn_avg_samples         = 4'h1 << setup[warn_avg_lsb +: 2]; // R8
        report_avg_samples       = 16'h0001 << avg_sel; // R9
        unique case (setup[ss_cfg_lsb +: 2]) // R4
            2'b00:   soft_start_cycles = 24'(ss_2p5ms_cyc);
            2'b01:   soft_start_cycles = 24'(ss_12p5ms_cyc);
            default: soft_start_cycles = 24'(ss_22p5ms_cyc);
        endcase
    end

endmodule

// File: logic/protection_config_telemetry_regs.sv
`timescale 1ns/10ps
// Notes on behaviour
// R1: Setup register D0h, 16 bits, resets 0000h.
// R2: Bits 15:14 select severe overcurrent deglitch.
// R3: Bit 13 disables current converter.
// R4: Bits 12:11 select soft-start delay.
// R5: Bits 9:8 select power-good threshold pair.
// R6: Bit 7 selects severe ratio 1.3/1.7.
// R7: Bits 6:5 select moderate overcurrent timeout.
// R8: Bits 1:0 select warning averaging count.
// R9: Averaging register DDh, low nibble, 2^n samples.
// R10: Host writes zero upper nibble; ignored.
// R11: Peak registers D1h-D4h and FDh, read-only.
// R12: Command D5h and reset peak_clear_command.
// R13: Voltage and temperature direct-format coefficients.
// R14: Current and power offsets and exponents.
// R15: Readings two's complement; 10 or 16 bit.
// R16: Peak replaced only by larger sample. A sample that arrives with a clear replaces it at any size.
// R17: Setup bits 10 and 4 have no effect.
module protection_config_telemetry_regs
    import telemetry_regs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    // Command port from the bus protocol engine.
    input  wire logic        cmd_valid,
    input  wire logic [7:0]  cmd_code,
    input  wire logic        cmd_write,
    input  wire logic        cmd_send_byte,
    input  wire logic [15:0] cmd_wdata,
    output logic [15:0]      cmd_rdata,
    output logic             cmd_ack,
    output logic             cmd_nack,
    // Measurements from the converters.
    input  wire logic        meas_valid,
    input  wire logic [9:0]  meas_vin,
    input  wire logic [9:0]  meas_iin,
    input  wire logic [9:0]  meas_vout,
    input  wire logic [9:0]  meas_iout,
    input  wire logic [9:0]  meas_temp,
    input  wire logic [15:0] meas_pin,
    input  wire logic [15:0] meas_ein,
    // Decoded settings to the protection logic.
    output severe_filter_t   severe_filter,
    output logic             iadc_enable,
    output logic [23:0]      soft_start_cycles,
    output logic [1:0]       power_good_threshold_sel,
    output logic             severe_ratio_high,
    output mocp_timeout_t    mocp_timeout,
    output logic [3:0]       warn_avg_samples,
    output logic [15:0]      report_avg_samples
);

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    logic [15:0] setup_r;
    logic [3:0]  avg_r;
    logic        wr_setup;
    logic        wr_avg;
    logic        peak_clear_command;

    assign wr_setup    = cmd_valid && cmd_write && cmd_code == cmd_device_setup;
    assign wr_avg      = cmd_valid && cmd_write && cmd_code == cmd_report_averaging_select;
    assign peak_clear_command = cmd_valid && cmd_send_byte && cmd_code == cmd_peak_clear_command; // R12

    // Unused bits are kept as written so a read returns them, but no decode looks at them.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            setup_r <= setup_reset; // R1
        end else if (wr_setup) begin
            setup_r <= cmd_wdata; // R1 R17
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            avg_r <= avg_reset;
        end else if (wr_avg) begin
            avg_r <= cmd_wdata[3:0]; // R9 R10
        end
    end

    setup_decode u_decode (
        .setup                    (setup_r & setup_used_mask), // R17
        .avg_sel                  (avg_r),
        .severe_filter            (severe_filter),
        .iadc_enable              (iadc_enable),
        .soft_start_cycles        (soft_start_cycles),
        .power_good_threshold_sel (power_good_threshold_sel),
        .severe_ratio_high        (severe_ratio_high),
        .mocp_timeout             (mocp_timeout),
        .warn_avg_samples         (warn_avg_samples),
        .report_avg_samples       (report_avg_samples)
    );

    // ----------------------------------------------------------------
    // Peak hold: vin, iout, pin, temp, vout
    // ----------------------------------------------------------------
    logic [15:0] peak_in  [num_peaks];
    logic [15:0] peak_val [num_peaks];

    assign peak_in[0] = {6'h00, meas_vin};
    assign peak_in[1] = {6'h00, meas_iout};
    assign peak_in[2] = meas_pin;
    assign peak_in[3] = {6'h00, meas_temp};
    assign peak_in[4] = {6'h00, meas_vout};

    genvar gi;
    generate
        for (gi = 0; gi < num_peaks; gi++) begin : g_peak
            peak_hold #(.w(16)) u_peak (
                .clk          (clk),
                .nrst         (nrst),
                .sample_valid (meas_valid),
                .sample       (peak_in[gi]),
                .clear        (peak_clear_command),
                .peak         (peak_val[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Readback
    // ----------------------------------------------------------------
    logic [15:0] rdata_nxt;
    logic        hit;
    logic [15:0] rdata_r;
    logic        ack_r;
    logic        nack_r;

    // Readings arrive already in direct format; 10-bit values sit in the low bits.
    always_comb begin
        hit       = 1'b1;
        rdata_nxt = 16'h0000;
        unique case (cmd_code)
            cmd_energy_accumulator_reading: rdata_nxt = meas_ein;
            cmd_input_voltage_reading:      rdata_nxt = {6'h00, meas_vin}; // R13 R15
            cmd_input_current_reading:      rdata_nxt = {6'h00, meas_iin}; // R14 R15
            cmd_output_voltage_reading:     rdata_nxt = {6'h00, meas_vout}; // R13 R15
            cmd_output_current_reading:     rdata_nxt = {6'h00, meas_iout}; // R14 R15
            cmd_temperature_reading:        rdata_nxt = {6'h00, meas_temp}; // R13 R15
            cmd_input_power_reading:        rdata_nxt = meas_pin; // R14 R15
            cmd_device_setup:               rdata_nxt = setup_r;
            cmd_peak_input_voltage:         rdata_nxt = peak_val[0]; // R11
            cmd_peak_output_current:        rdata_nxt = peak_val[1]; // R11
            cmd_peak_input_power:           rdata_nxt = peak_val[2]; // R11
            cmd_peak_temperature:           rdata_nxt = peak_val[3]; // R11
            cmd_report_averaging_select:    rdata_nxt = {12'h000, avg_r};
            cmd_peak_output_voltage:        rdata_nxt = peak_val[4]; // R11
            cmd_peak_clear_command:         rdata_nxt = 16'h0000;
            default:                        hit = 1'b0;
        endcase
    end

    // Writes to read-only codes are refused so the host sees the mistake.
    logic legal;
    always_comb begin
        if (cmd_send_byte) begin
            legal = cmd_code == cmd_peak_clear_command;
        end else if (cmd_write) begin
            legal = cmd_code == cmd_device_setup || cmd_code == cmd_report_averaging_select;
        end else begin
            legal = hit && cmd_code != cmd_peak_clear_command;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= 16'h0000;
        end else if (cmd_valid && !cmd_write && !cmd_send_byte) begin
            rdata_r <= rdata_nxt;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ack_r  <= 1'b0;
            nack_r <= 1'b0;
        end else begin
            ack_r  <= cmd_valid && legal;
            nack_r <= cmd_valid && !legal;
        end
    end

    assign cmd_rdata = rdata_r;
    assign cmd_ack   = ack_r;
    assign cmd_nack  = nack_r;

endmodule

// File: verification/telemetry_regs_asserts.sv
`timescale 1ns/10ps
module telemetry_regs_asserts
    import telemetry_regs_pkg::*;
(
    input wire logic           clk,
    input wire logic           nrst,
    input wire logic           cmd_valid,
    input wire logic [7:0]     cmd_code,
    input wire logic           cmd_write,
    input wire logic           cmd_send_byte,
    input wire logic [15:0]    cmd_wdata,
    input wire logic           cmd_ack,
    input wire logic           cmd_nack,
    input wire severe_filter_t severe_filter,
    input wire logic           iadc_enable,
    input wire logic [23:0]    soft_start_cycles,
    input wire logic [1:0]     power_good_threshold_sel,
    input wire logic           severe_ratio_high,
    input wire mocp_timeout_t  mocp_timeout,
    input wire logic [3:0]     warn_avg_samples,
    input wire logic [15:0]    report_avg_samples
);
    // --------------------------------------------------------------
    // Answer and field checks
    // --------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    logic setw;
    assign setw = cmd_valid && cmd_write && cmd_code == cmd_device_setup;
    a_one_answer: assert property (cmd_valid |=> cmd_ack != cmd_nack)
        else $error("command not answered once");
    a_no_idle_answer: assert property (!cmd_valid |=> !cmd_ack && !cmd_nack)
        else $error("answer without command");
    a_filter_field: assert property (setw |=> severe_filter == $past(cmd_wdata[15:14]))
        else $error("filter field wrong");
    a_iadc_field: assert property (setw |=> iadc_enable == !$past(cmd_wdata[13]))
        else $error("converter enable wrong");
    a_soft_start: assert property (setw |=> soft_start_cycles == ($past(cmd_wdata[12]) ? 24'h036ee8 :
        $past(cmd_wdata[11]) ? 24'h01e848 : 24'h0061a8)) else $error("soft start count wrong");
    a_pg_field: assert property (setw |=> power_good_threshold_sel == $past(cmd_wdata[9:8]))
        else $error("threshold field wrong");
    a_ratio_field: assert property (setw |=> severe_ratio_high == $past(cmd_wdata[7]))
        else $error("ratio field wrong");
    a_mocp_field: assert property (setw |=> mocp_timeout == $past(cmd_wdata[6:5]))
        else $error("timeout field wrong");
    a_warn_count: assert property (setw |=> warn_avg_samples == 4'h1 << $past(cmd_wdata[1:0]))
        else $error("warning average wrong");
    a_setup_held: assert property (!setw |=> $stable(severe_filter) && $stable(mocp_timeout))
        else $error("setup changed without write");
    a_report_avg: assert property (cmd_valid && cmd_write && cmd_code == cmd_report_averaging_select
        |=> report_avg_samples == 16'h0001 << $past(cmd_wdata[3:0])) else $error("report average wrong");
    a_peak_ro: assert property (cmd_valid && cmd_write && cmd_code == cmd_peak_input_voltage |=> cmd_nack)
        else $error("peak write accepted");
    a_clear_ack: assert property (cmd_valid && cmd_send_byte && cmd_code == cmd_peak_clear_command |=> cmd_ack)
        else $error("clear not accepted");
endmodule
bind protection_config_telemetry_regs telemetry_regs_asserts chk_u (.clk, .nrst, .cmd_valid, .cmd_code,
    .cmd_write, .cmd_send_byte, .cmd_wdata, .cmd_ack, .cmd_nack, .severe_filter, .iadc_enable,
    .soft_start_cycles, .power_good_threshold_sel, .severe_ratio_high, .mocp_timeout,
    .warn_avg_samples, .report_avg_samples);

// File: verification/host_model.sv
`timescale 1ns/10ps
module host_model
    import telemetry_regs_pkg::*;
(
    input  wire logic        clk,
    output logic             cmd_valid,
    output logic [7:0]       cmd_code,
    output logic             cmd_write,
    output logic             cmd_send_byte,
    output logic [15:0]      cmd_wdata,
    input  wire logic [15:0] cmd_rdata,
    input  wire logic        cmd_ack,
    input  wire logic        cmd_nack
);
    // --------------------------------------------------------------
    // One command per call, answer taken one cycle later
    // --------------------------------------------------------------
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 8'h00;
        cmd_write = 1'b0;
        cmd_send_byte = 1'b0;
        cmd_wdata = 16'h0000;
    end
    task automatic xfer(input logic [7:0] c, input logic wr, input logic sb, input logic [15:0] wd,
                        output logic [15:0] rd, output logic ak, output logic nk);
        @(posedge clk);
        #1;
        if (wr && c == cmd_report_averaging_select) wd[15:4] = 12'h000;
        cmd_valid = 1'b1;
        cmd_code = c;
        cmd_write = wr;
        cmd_send_byte = sb;
        cmd_wdata = wd;
        @(posedge clk);
        #1;
        rd = cmd_rdata;
        ak = cmd_ack;
        nk = cmd_nack;
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_send_byte = 1'b0;
        // Released lines carry garbage so a stale value is never mistaken for a command.
        cmd_code = ~c;
        cmd_wdata = ~wd;
    endtask
endmodule

// File: verification/protection_config_telemetry_regs_tb_top.sv
`timescale 1ns/10ps
module protection_config_telemetry_regs_tb_top
    import telemetry_regs_pkg::*;
;
    typedef struct packed {logic [15:0] wd; logic [11:0] dec; logic [23:0] ss;} row_t;
    row_t rows [4] = '{'{16'h0000, 12'h201, 24'h0061a8}, '{16'h4921, 12'h692, 24'h01e848},
                       '{16'hb2c2, 12'h964, 24'h036ee8}, '{16'hfff3, 12'hdf8, 24'h036ee8}};
    logic [7:0]     pk_code [5] = '{8'hd1, 8'hd2, 8'hd3, 8'hd4, 8'hfd};
    logic           clk, nrst, cmd_valid, cmd_write, cmd_send_byte, cmd_ack, cmd_nack, ak, nk;
    logic           meas_valid, iadc_enable, severe_ratio_high;
    logic [7:0]     cmd_code;
    logic [9:0]     meas_vin, meas_iin, meas_vout, meas_iout, meas_temp;
    logic [15:0]    cmd_wdata, cmd_rdata, meas_pin, meas_ein, rd, report_avg_samples;
    logic [23:0]    soft_start_cycles;
    logic [1:0]     power_good_threshold_sel;
    logic [3:0]     warn_avg_samples;
    severe_filter_t severe_filter;
    mocp_timeout_t  mocp_timeout;
    int             error_cnt, cmp_count;
    protection_config_telemetry_regs dut_u (.clk, .nrst, .cmd_valid, .cmd_code, .cmd_write, .cmd_send_byte,
        .cmd_wdata, .cmd_rdata, .cmd_ack, .cmd_nack, .meas_valid, .meas_vin, .meas_iin, .meas_vout, .meas_iout,
        .meas_temp, .meas_pin, .meas_ein, .severe_filter, .iadc_enable, .soft_start_cycles,
        .power_good_threshold_sel, .severe_ratio_high, .mocp_timeout, .warn_avg_samples, .report_avg_samples);
    host_model host_u (.clk, .cmd_valid, .cmd_code, .cmd_write, .cmd_send_byte, .cmd_wdata, .cmd_rdata,
        .cmd_ack, .cmd_nack);
    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] c, input logic wr, input logic sb, input logic [15:0] wd);
        host_u.xfer(c, wr, sb, wd, rd, ak, nk);
    endtask
    task automatic sample(input logic [9:0] v, input logic [15:0] p);
        @(posedge clk);
        #1;
        meas_valid = 1'b1;
        {meas_vin, meas_iout, meas_temp, meas_vout, meas_iin} = {v, v + 10'h1, v + 10'h3, v + 10'h4, v};
        {meas_pin, meas_ein} = {p, p};
        @(posedge clk);
        #1;
        meas_valid = 1'b0;
    endtask
    // Peak i holds v plus i, except input power which holds p.
    task automatic check_peaks(input logic [9:0] v, input logic [15:0] p, input bit z);
        for (int i = 0; i < 5; i++) begin
            cmd(pk_code[i], 1'b0, 1'b0, 16'h0000);
            chk(rd, z ? 24'h0 : (i == 2 ? 24'(p) : 24'(v) + 24'(i)));
        end
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        stop_test();
    end
    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        {nrst, meas_valid, meas_vin, meas_iin, meas_vout, meas_iout, meas_temp, meas_pin, meas_ein} = '0;
        repeat (6) @(posedge clk);
        #1;
        nrst = 1'b1;
        chk({iadc_enable, warn_avg_samples, report_avg_samples}, {1'b1, 4'h1, 16'h0001});
        chk(soft_start_cycles, 24'h0061a8);
        cmd(cmd_device_setup, 1'b0, 1'b0, 16'h0000);
        chk(rd, 24'h0);
        check_peaks(10'h0, 16'h0, 1'b1);
        $display("test reset done");
        foreach (rows[i]) begin
            cmd(cmd_device_setup, 1'b1, 1'b0, rows[i].wd);
            chk({ak, nk}, 2'b10);
            chk({severe_filter, iadc_enable, power_good_threshold_sel, severe_ratio_high, mocp_timeout,
                 warn_avg_samples}, rows[i].dec);
            chk(soft_start_cycles, rows[i].ss);
            cmd(cmd_device_setup, 1'b0, 1'b0, 16'h0000);
            chk(rd, rows[i].wd);
        end
        $display("test setup rows done");
        for (int n = 0; n < 16; n++) begin
            cmd(cmd_report_averaging_select, 1'b1, 1'b0, 16'(n));
            chk(report_avg_samples, 16'h0001 << n);
            cmd(cmd_report_averaging_select, 1'b0, 1'b0, 16'h0000);
            chk(rd, 24'(n));
        end
        $display("test averaging done");
        sample(10'h155, 16'h4001);
        sample(10'h0aa, 16'h3fff);
        check_peaks(10'h155, 16'h4001, 1'b0);
        sample(10'h2aa, 16'h5000);
        check_peaks(10'h2aa, 16'h5000, 1'b0);
        cmd(cmd_input_voltage_reading, 1'b0, 1'b0, 16'h0000);
        chk(rd, 24'h0002aa);
        cmd(cmd_input_power_reading, 1'b0, 1'b0, 16'h0000);
        chk(rd, 24'h005000);
        cmd(cmd_input_current_reading, 1'b0, 1'b0, 16'h0000);
        chk(rd, 24'h0002aa);
        cmd(cmd_output_current_reading, 1'b0, 1'b0, 16'h0000);
        chk(rd, 24'h0002ab);
        cmd(cmd_output_voltage_reading, 1'b0, 1'b0, 16'h0000);
        chk(rd, 24'h0002ae);
        cmd(cmd_temperature_reading, 1'b0, 1'b0, 16'h0000);
        chk(rd, 24'h0002ad);
        cmd(cmd_energy_accumulator_reading, 1'b0, 1'b0, 16'h0000);
        chk(rd, 24'h005000);
        cmd(8'h00, 1'b0, 1'b0, 16'h0000);
        chk({ak, nk, rd}, 18'h10000);
        cmd(cmd_peak_input_voltage, 1'b1, 1'b0, 16'h1234);
        chk({ak, nk}, 2'b01);
        cmd(cmd_peak_clear_command, 1'b0, 1'b1, 16'h0000);
        chk({ak, nk}, 2'b10);
        check_peaks(10'h0, 16'h0, 1'b1);
        cmd(cmd_peak_clear_command, 1'b0, 1'b0, 16'h0000);
        chk({ak, nk}, 2'b01);
        $display("test peaks done");
        cmd(cmd_device_setup, 1'b1, 1'b0, 16'h4921);
        nrst = 1'b0;
        @(posedge clk);
        #1;
        nrst = 1'b1;
        chk({severe_filter, iadc_enable, power_good_threshold_sel, severe_ratio_high, mocp_timeout,
             warn_avg_samples}, 12'h201);
        chk(soft_start_cycles, 24'h0061a8);
        cmd(cmd_device_setup, 1'b0, 1'b0, 16'h0000);
        chk(rd, 24'h0);
        $display("test mid-run reset done");
        stop_test();
    end
endmodule
